// *** logic/pwp_pkg.sv ***
/*
  shared constants and carriers for the persistence, wait and pulse block.
  assumes a 100 MHz core clock and an 8-bit register port from the serial front end.
*/
package pwp_pkg;
  localparam int CLK_PERIOD_NS = 10;

  localparam logic [7:0] ADDR_PERSIST = 8'h8c;
  localparam logic [7:0] ADDR_GEN_CFG = 8'h8d;
  localparam logic [7:0] ADDR_PULSE_CFG = 8'h8e;

  localparam logic [7:0] RST_PERSIST = 8'h00;
  localparam logic [7:0] RST_GEN_CFG = 8'h80;
  localparam logic [7:0] RST_PULSE_CFG = 8'h4f;

  localparam int PROX_PERSISTENCE_FILTER_CONFIG_MSB = 7;
  localparam int PROX_PERSISTENCE_FILTER_CONFIG_LSB = 4;
  localparam int AMB_PERSISTENCE_FILTER_CONFIG_MSB = 3;
  localparam int AMB_PERSISTENCE_FILTER_CONFIG_LSB = 0;
  localparam int LONG_WAIT_BIT = 2;
  localparam int PULSE_SEL_MSB = 7;
  localparam int PULSE_SEL_LSB = 6;
  localparam int PULSE_CNT_MSB = 5;
  localparam int PULSE_CNT_LSB = 0;

  // ambient persistence: codes above this step in multiples of five
  localparam logic [3:0] AMB_LINEAR_MAX = 4'h3;
  localparam logic [2:0] AMB_STEP = 3'h5;
  localparam logic [3:0] LONG_WAIT_FACTOR = 4'hc;

  // wait increment, in tenths of microseconds (2.8 ms)
  localparam int WAIT_UNIT_US_X10 = 28000;
  localparam int WAIT_UNIT_CYCLES = WAIT_UNIT_US_X10 * 100 / CLK_PERIOD_NS;

  // shortest led pulse, 4 us; each width step doubles it
  localparam int PULSE_BASE_NS = 4000;
  localparam int PULSE_BASE_CYC_I = PULSE_BASE_NS / CLK_PERIOD_NS;
  localparam logic [11:0] PULSE_BASE_CYCLES = PULSE_BASE_CYC_I[11:0];

  typedef enum logic [1:0] {
    PWP_IDLE = 2'b00,
    PWP_LED_ON = 2'b01,
    PWP_LED_OFF = 2'b11
  } pwp_pulse_e;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pwp_reg_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] prox_data;
    logic [7:0] prox_low_threshold;
    logic [7:0] prox_high_threshold;
  } pwp_prox_res_s;

  typedef struct packed {
    logic valid;
    logic [15:0] clear_data;
    logic [15:0] low_threshold;
    logic [15:0] high_threshold;
  } pwp_amb_res_s;
endpackage

// *** logic/pwp_top.sv ***
/*
  persistence filters, wait down counter and proximity led pulse engine.
  assumes register requests, results and thresholds arrive from logic on clk_i,
  so none of them is resynchronised here.
*/
// What this block does
// - bits 7:4 pick the proximity filter: 0 every cycle, 1 any miss, 2..15 misses in a row.
// - bits 3:0 pick the ambient filter: 0..3 as for proximity, 4..15 need 5*(code-3) misses.
// - consecutive proximity misses are counted; the flag fires when the count equals the code.
// - a proximity result inside the window clears the proximity count.
// - consecutive clear-channel misses are counted; the flag fires at the required count.
// - a clear-channel result inside the window clears the ambient count.
// - the wait period is a down counter of (wait setting plus one) steps of 2.8 ms.
// - with the long-wait bit set the wait period is twelve times longer.
// - pulse width select gives 4, 8, 16 or 32 us led pulses.
// - the pulse count field plus one is the most pulses per proximity cycle, 1 to 64.
// - pulses are added until the maximum is reached or near saturation or a far target is seen.
// - the proximity cycle is cut short when the target is very close or very far.
// - a miss lies outside the 8-bit proximity window; events set the flag and the enabled pin.
// - a miss lies outside the 16-bit ambient window; events set the flag and the enabled pin.
`timescale 1ns/100ps
module pwp_top import pwp_pkg::*; #(
  parameter int WAIT_UNIT_CYC = WAIT_UNIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pwp_reg_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire pwp_prox_res_s prox_res_i,
  input wire pwp_amb_res_s amb_res_i,
  input wire logic prox_irq_enable_i,
  input wire logic ambient_irq_enable_i,
  input wire logic prox_irq_clear_i,
  input wire logic ambient_irq_clear_i,
  input wire logic [7:0] wait_setting_i,
  input wire logic wait_start_i,
  input wire logic prox_cycle_start_i,
  input wire logic near_sat_i,
  input wire logic far_target_i,
  output logic prox_irq_flag_o,
  output logic ambient_irq_flag_o,
  output logic int_o,
  output logic wait_busy_o,
  output logic wait_done_o,
  output logic led_pulse_o,
  output logic prox_cycle_done_o,
  output logic prox_cycle_short_o
);
  typedef struct packed {
    logic [7:0] persist;
    logic [7:0] gen_cfg;
    logic [7:0] pulse_cfg;
    logic [7:0] rdata;
    logic [5:0] prox_persist_count;
    logic [5:0] ambient_persist_count;
    logic prox_flag;
    logic amb_flag;
    logic irq;
    logic [18:0] tick_cnt;
    logic [11:0] wait_units;
    logic wait_busy;
    logic wait_done;
    pwp_pulse_e pstate;
    logic [11:0] width_cnt;
    logic [6:0] pulses;
    logic led;
    logic cyc_done;
    logic cyc_short;
  } pwp_state_s;

  pwp_state_s s_q, s_d;

  localparam logic [18:0] UNIT_LAST = 19'(WAIT_UNIT_CYC - 1);

  // consecutive-miss count that satisfies an ambient persistence code
  function automatic logic [5:0] amb_required(input logic [3:0] code);
    logic [3:0] over;
    over = code - AMB_LINEAR_MAX;
    if (code <= AMB_LINEAR_MAX) begin
      amb_required = {2'b00, code};
    end else begin
      amb_required = 6'({2'b00, over} * 6'(AMB_STEP));
    end
  endfunction

  // new miss count after one result; a hit clears it, saturate to avoid wrap re-firing
  function automatic logic [5:0] next_count(input logic miss, input logic [5:0] cnt);
    if (!miss) begin
      next_count = '0;
    end else if (&cnt) begin
      next_count = cnt;
    end else begin
      next_count = cnt + 6'h01;
    end
  endfunction

  logic prox_miss, amb_miss, prox_event, amb_event;
  logic [5:0] prox_cnt_n, amb_cnt_n;
  logic [3:0] prox_code, amb_code;
  logic [11:0] width_last;
  logic [6:0] pulse_max;

  always_comb begin
    s_d = s_q;
    prox_code = s_q.persist[PROX_PERSISTENCE_FILTER_CONFIG_MSB:PROX_PERSISTENCE_FILTER_CONFIG_LSB];
    amb_code = s_q.persist[AMB_PERSISTENCE_FILTER_CONFIG_MSB:AMB_PERSISTENCE_FILTER_CONFIG_LSB];
    width_last = (PULSE_BASE_CYCLES << s_q.pulse_cfg[PULSE_SEL_MSB:PULSE_SEL_LSB])
                 - 12'h001;
    pulse_max = {1'b0, s_q.pulse_cfg[PULSE_CNT_MSB:PULSE_CNT_LSB]} + 7'h01;

    // register port
    if (reg_req_i.we) begin
      unique case (reg_req_i.addr)
        ADDR_PERSIST: s_d.persist = reg_req_i.wdata;
        ADDR_GEN_CFG: s_d.gen_cfg = reg_req_i.wdata; // reserved bits kept as written
        ADDR_PULSE_CFG: s_d.pulse_cfg = reg_req_i.wdata;
        default: ;
      endcase
    end
    if (reg_req_i.re) begin
      unique case (reg_req_i.addr)
        ADDR_PERSIST: s_d.rdata = s_q.persist;
        ADDR_GEN_CFG: s_d.rdata = s_q.gen_cfg;
        ADDR_PULSE_CFG: s_d.rdata = s_q.pulse_cfg;
        default: s_d.rdata = '0;
      endcase
    end

    // proximity persistence
    prox_miss = (prox_res_i.prox_data < prox_res_i.prox_low_threshold) ||
                (prox_res_i.prox_data > prox_res_i.prox_high_threshold);
    prox_cnt_n = next_count(prox_miss, s_q.prox_persist_count);
    prox_event = prox_res_i.valid && ((prox_code == '0) ||
                 (prox_miss && prox_cnt_n == {2'b00, prox_code}));
    if (prox_res_i.valid) begin
      s_d.prox_persist_count = prox_cnt_n;
    end

    // ambient persistence
    amb_miss = (amb_res_i.clear_data < amb_res_i.low_threshold) ||
               (amb_res_i.clear_data > amb_res_i.high_threshold);
    amb_cnt_n = next_count(amb_miss, s_q.ambient_persist_count);
    amb_event = amb_res_i.valid &&
                ((amb_code == '0) || (amb_miss && amb_cnt_n == amb_required(amb_code)));
    if (amb_res_i.valid) begin
      s_d.ambient_persist_count = amb_cnt_n;
    end

    // flags: a new event beats a clear in the same cycle
    if (prox_irq_clear_i) begin
      s_d.prox_flag = 1'b0;
    end
    if (prox_event) begin
      s_d.prox_flag = 1'b1;
    end
    if (ambient_irq_clear_i) begin
      s_d.amb_flag = 1'b0;
    end
    if (amb_event) begin
      s_d.amb_flag = 1'b1;
    end
    s_d.irq = (s_d.prox_flag && prox_irq_enable_i) || (s_d.amb_flag && ambient_irq_enable_i);

    // wait down counter, one unit per 2.8 ms tick
    s_d.wait_done = 1'b0;
    if (wait_start_i) begin
      s_d.wait_busy = 1'b1;
      s_d.tick_cnt = UNIT_LAST;
      if (s_q.gen_cfg[LONG_WAIT_BIT]) begin
        s_d.wait_units = 12'(({4'h0, wait_setting_i} + 12'h001) * LONG_WAIT_FACTOR);
      end else begin
        s_d.wait_units = {4'h0, wait_setting_i} + 12'h001;
      end
    end else if (s_q.wait_busy) begin
      if (s_q.tick_cnt != '0) begin
        s_d.tick_cnt = s_q.tick_cnt - 19'h00001;
      end else begin
        s_d.tick_cnt = UNIT_LAST;
        s_d.wait_units = s_q.wait_units - 12'h001;
        if (s_q.wait_units == 12'h001) begin
          s_d.wait_busy = 1'b0;
          s_d.wait_done = 1'b1;
        end
      end
    end

    // led pulse engine: equal on and off times per pulse
    s_d.cyc_done = 1'b0;
    unique case (s_q.pstate)
      PWP_IDLE: begin
        if (prox_cycle_start_i) begin
          s_d.pstate = PWP_LED_ON;
          s_d.led = 1'b1;
          s_d.width_cnt = '0;
          s_d.pulses = 7'h01;
          s_d.cyc_short = 1'b0;
        end
      end
      PWP_LED_ON: begin
        if (s_q.width_cnt == width_last) begin
          s_d.pstate = PWP_LED_OFF;
          s_d.led = 1'b0;
          s_d.width_cnt = '0;
        end else begin
          s_d.width_cnt = s_q.width_cnt + 12'h001;
        end
      end
      PWP_LED_OFF: begin
        if (s_q.width_cnt != width_last) begin
          s_d.width_cnt = s_q.width_cnt + 12'h001;
        end else if (near_sat_i || far_target_i) begin
          s_d.pstate = PWP_IDLE; // close or weak target: end early
          s_d.cyc_done = 1'b1;
          s_d.cyc_short = s_q.pulses != pulse_max;
        end else if (s_q.pulses == pulse_max) begin
          s_d.pstate = PWP_IDLE;
          s_d.cyc_done = 1'b1;
        end else begin
          s_d.pstate = PWP_LED_ON;
          s_d.led = 1'b1;
          s_d.width_cnt = '0;
          s_d.pulses = s_q.pulses + 7'h01;
        end
      end
      default: begin
        s_d.pstate = PWP_IDLE;
        s_d.led = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0; // counters cleared
      s_q.persist <= RST_PERSIST;
      s_q.gen_cfg <= RST_GEN_CFG;
      s_q.pulse_cfg <= RST_PULSE_CFG;
      s_q.pstate <= PWP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign prox_irq_flag_o = s_q.prox_flag;
  assign ambient_irq_flag_o = s_q.amb_flag;
  assign int_o = s_q.irq;
  assign wait_busy_o = s_q.wait_busy;
  assign wait_done_o = s_q.wait_done;
  assign led_pulse_o = s_q.led;
  assign prox_cycle_done_o = s_q.cyc_done;
  assign prox_cycle_short_o = s_q.cyc_short;
endmodule

// *** tb/pwp_host.sv ***
/*
  host model issuing byte register requests on the block's register port.
  assumes requests launch 1 ns after a rising edge of clk_i.
*/
`timescale 1ns/100ps
module pwp_host import pwp_pkg::*; (
  input wire logic clk_i,
  output pwp_reg_req_s req_o
);
  initial req_o = '0;
  // idle lines show the inverse of the last value so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    req_o = '{we: w, re: !w, addr: a, wdata: d};
    @(posedge clk_i);
    #1;
    req_o = '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic wr_gen(input logic long_wait);
    xfer(1'b1, ADDR_GEN_CFG, {5'b10000, long_wait, 2'b00});
  endtask
endmodule

// *** tb/pwp_top_properties.sv ***
/*
  concurrent checks on the persistence, wait and pulse block ports.
  assumes it is bound into pwp_top and handed the same wait unit parameter.
*/
`timescale 1ns/100ps
module pwp_top_properties import pwp_pkg::*; #(
  parameter int WAIT_UNIT_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pwp_prox_res_s prox_res_i,
  input wire pwp_amb_res_s amb_res_i,
  input wire logic prox_irq_enable_i,
  input wire logic ambient_irq_enable_i,
  input wire logic prox_irq_clear_i,
  input wire logic wait_start_i,
  input wire logic prox_cycle_start_i,
  input wire logic prox_irq_flag_o,
  input wire logic ambient_irq_flag_o,
  input wire logic int_o,
  input wire logic wait_busy_o,
  input wire logic led_pulse_o,
  input wire logic prox_cycle_done_o,
  input wire logic prox_cycle_short_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // length of the current led pulse, so a width can be judged at its falling edge
  logic [12:0] on_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_q <= '0;
    end else begin
      on_q <= led_pulse_o ? on_q + 13'h1 : '0;
    end
  end
  property p_int;
    int_o == ((prox_irq_flag_o && $past(prox_irq_enable_i))
      || (ambient_irq_flag_o && $past(ambient_irq_enable_i)));
  endproperty
  a_int: assert property (p_int) else $error("int pin mismatch");
  property p_prox_rise;
    $rose(prox_irq_flag_o) |-> $past(prox_res_i.valid);
  endproperty
  a_prox_rise: assert property (p_prox_rise) else $error("prox flag without result");
  property p_amb_rise;
    $rose(ambient_irq_flag_o) |-> $past(amb_res_i.valid);
  endproperty
  a_amb_rise: assert property (p_amb_rise) else $error("amb flag without result");
  property p_prox_fall;
    $fell(prox_irq_flag_o) |-> $past(prox_irq_clear_i);
  endproperty
  a_prox_fall: assert property (p_prox_fall) else $error("prox flag lost");
  property p_wait;
    wait_start_i |=> wait_busy_o [*4];
  endproperty
  a_wait: assert property (p_wait) else $error("wait not busy");
  property p_led_w;
    $fell(led_pulse_o) |-> on_q >= 13'h190 && on_q <= 13'hc80;
  endproperty
  a_led_w: assert property (p_led_w) else $error("led width out of set");
  property p_done;
    prox_cycle_done_o |-> !led_pulse_o && !$past(led_pulse_o);
  endproperty
  a_done: assert property (p_done) else $error("done during pulse");
  property p_short_fall;
    $fell(prox_cycle_short_o) |-> $past(prox_cycle_start_i);
  endproperty
  a_short_fall: assert property (p_short_fall) else $error("short flag lost");
endmodule
bind pwp_top pwp_top_properties #(.WAIT_UNIT_CYC(WAIT_UNIT_CYC)) u_pwp_top_properties (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .prox_res_i(prox_res_i), .amb_res_i(amb_res_i),
  .prox_irq_enable_i(prox_irq_enable_i), .ambient_irq_enable_i(ambient_irq_enable_i),
  .prox_irq_clear_i(prox_irq_clear_i), .wait_start_i(wait_start_i),
  .prox_cycle_start_i(prox_cycle_start_i), .prox_irq_flag_o(prox_irq_flag_o),
  .ambient_irq_flag_o(ambient_irq_flag_o), .int_o(int_o), .wait_busy_o(wait_busy_o),
  .led_pulse_o(led_pulse_o), .prox_cycle_done_o(prox_cycle_done_o),
  .prox_cycle_short_o(prox_cycle_short_o));

// *** tb/tb.sv ***
/*
  self-checking bench for the persistence, wait and pulse block.
  assumes a wait unit shortened to 4 cycles.
*/
`timescale 1ns/100ps
module tb import pwp_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  pwp_reg_req_s req;
  pwp_prox_res_s pr = '0;
  pwp_amb_res_s ar = '0;
  logic [7:0] rdata;
  logic [7:0] wset = 8'h01;
  logic pen, aen, pclr, aclr, wst, pst, nsat, far;
  logic pflag, aflag, irq, wbusy, wdone, led, pdone, pshort;
  int n_fail = 0;
  int num_checks = 0;
  always #5 clk_i = ~clk_i;
  pwp_host u_pwp_host (.clk_i(clk_i), .req_o(req));
  pwp_top #(.WAIT_UNIT_CYC(4)) u_pwp_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .prox_res_i(pr), .amb_res_i(ar), .prox_irq_enable_i(pen),
    .ambient_irq_enable_i(aen), .prox_irq_clear_i(pclr), .ambient_irq_clear_i(aclr),
    .wait_setting_i(wset), .wait_start_i(wst), .prox_cycle_start_i(pst), .near_sat_i(nsat),
    .far_target_i(far), .prox_irq_flag_o(pflag), .ambient_irq_flag_o(aflag), .int_o(irq),
    .wait_busy_o(wbusy), .wait_done_o(wdone), .led_pulse_o(led), .prox_cycle_done_o(pdone),
    .prox_cycle_short_o(pshort));
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic pres(input logic [7:0] d);
    pr = '{1'b1, d, 8'h20, 8'h80};
    tick();
    pr = '{1'b0, ~d, 8'h20, 8'h80};
    tick();
  endtask
  task automatic ares(input logic [15:0] d);
    ar = '{1'b1, d, 16'h1000, 16'h8000};
    tick();
    ar = '{1'b0, ~d, 16'h1000, 16'h8000};
    tick();
  endtask
  task automatic t_reset();
    logic [7:0] adr [4];
    logic [7:0] exp [4];
    adr = '{ADDR_PERSIST, ADDR_GEN_CFG, ADDR_PULSE_CFG, 8'h90};
    exp = '{RST_PERSIST, RST_GEN_CFG, RST_PULSE_CFG, 8'h00};
    for (int i = 0; i < 4; i++) begin
      u_pwp_host.xfer(1'b0, adr[i], 8'h00);
      chk(rdata === exp[i], "reset value");
    end
  endtask
  task automatic t_persist();
    pen = 1'b1;
    u_pwp_host.xfer(1'b1, ADDR_PERSIST, 8'h34);
    u_pwp_host.xfer(1'b0, ADDR_PERSIST, 8'h00);
    chk(rdata === 8'h34, "persist readback");
    repeat (2) pres(8'h10);
    pres(8'h50);
    repeat (2) pres(8'h90);
    chk(!pflag, "prox early");
    pres(8'h90);
    chk(pflag && irq, "prox third miss");
    pclr = 1'b1;
    tick();
    pclr = 1'b0;
    pres(8'h90);
    chk(!pflag, "prox refire");
    repeat (4) ares(16'h0010);
    ares(16'h4000);
    repeat (4) ares(16'h9000);
    chk(!aflag, "amb early");
    ares(16'h9000);
    chk(aflag && !irq, "amb fifth miss");
    aen = 1'b1;
    tick();
    chk(irq, "amb enable");
    u_pwp_host.xfer(1'b1, ADDR_PERSIST, 8'h00);
    aclr = 1'b1;
    tick();
    aclr = 1'b0;
    pres(8'h50);
    ares(16'h4000);
    chk(pflag && aflag, "code zero");
  endtask
  task automatic t_wait(input logic lw, input int exp);
    int n;
    u_pwp_host.wr_gen(lw);
    wst = 1'b1;
    tick();
    wst = 1'b0;
    chk(wbusy === 1'b1, "wait not busy");
    n = 1;
    while (wdone !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    chk(n == exp, "wait length");
    chk(wbusy === 1'b0, "busy after done");
    if (n >= 300) final_report();
  endtask
  task automatic t_pulse(input logic [7:0] cfg, input logic s, input logic f, input int np_exp,
    input logic sh);
    int n, np, w;
    logic prev;
    u_pwp_host.xfer(1'b1, ADDR_PULSE_CFG, cfg);
    nsat = s;
    far = f;
    pst = 1'b1;
    tick();
    pst = 1'b0;
    {n, np, w} = '0;
    prev = 1'b0;
    // count rising edges of the led and the length of the first pulse only
    while (pdone !== 1'b1 && n < 20000) begin
      if (led === 1'b1 && prev !== 1'b1) begin
        np++;
      end
      if (led === 1'b1 && np == 1) begin
        w++;
      end
      prev = led;
      tick();
      n++;
    end
    chk(n < 20000, "pulse timeout");
    if (n >= 20000) final_report();
    chk(w == (PULSE_BASE_CYC_I << cfg[7:6]), "pulse width");
    chk(np == np_exp, "pulse count");
    chk(pshort === sh, "short flag");
    {nsat, far} = 2'b00;
  endtask
  initial begin
    {pen, aen, pclr, aclr, wst, pst, nsat, far} = 8'h00;
    repeat (20) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_persist();
    t_wait(1'b0, 2 * 4 + 1);
    t_wait(1'b1, 2 * 12 * 4 + 1);
    t_pulse(8'h41, 1'b0, 1'b0, 2, 1'b0);
    t_pulse(8'h41, 1'b1, 1'b0, 1, 1'b1);
    t_pulse(8'hc1, 1'b0, 1'b1, 1, 1'b1);
    t_pulse(8'h00, 1'b0, 1'b0, 1, 1'b0);
    t_pulse(8'h80, 1'b0, 1'b0, 1, 1'b0);
    final_report();
  end
endmodule
